// ### src/cmot_regs.sv
// Purpose: Common-mode and I-channel offset trim registers
// Assumes: Serial decoder delivers a one-cycle write strobe and read address
// Notes:   Runs on the serial interface clock; values persist until reset
`timescale 1ns/1ps
`default_nettype none
`include "cmot_cfg.svh"

module cmot_regs (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   // Register access from the serial decoder
   input wire cmot_pkg::cmot_req_t req_in,
   input wire logic [3:0] rd_addr_in,
   output logic [15:0] rd_data_out,
   output logic rd_hit_out,
   // Trim values toward the analog circuits
   output cmot_pkg::cmot_trim_t trim_out
);

   // Stored fields; reserved ones are kept as written, not forced
   logic [7:0] cm_rsv_hi_reg;
   logic [2:0] cm_code_reg;
   logic [4:0] cm_rsv_lo_reg;
   logic [2:0] ofs_rsv_reg;
   logic ofs_pol_reg;
   logic [11:0] ofs_size_reg;

   // Whole words as they read back
   logic [15:0] cm_trim_word;
   logic [15:0] ofs_trim_word;

   // Write decode
   logic cm_wr_sel;
   logic ofs_wr_sel;

   // Read decode
   logic cm_rd_sel;
   logic ofs_rd_sel;
   logic rd_hit_next;
   logic [15:0] rd_data_next;

   // Field values headed for the trim outputs
   cmot_pkg::cmot_trim_t trim_next;

   // Reset words as vectors, so that fields can be selected from them
   localparam logic [15:0] cm_reset_word = `CMOT_CM_TRIM_RESET;
   localparam logic [15:0] ofs_reset_word = `CMOT_OFS_TRIM_RESET;

   // Address compare shared by the write and read decoders
   function automatic logic addr_is(
      input logic [3:0] a,
      input logic [3:0] reg_addr
   );
      addr_is = (a == reg_addr);
   endfunction

   // A write counts only with the strobe up and a matching address
   function automatic logic wr_targets(
      input cmot_pkg::cmot_req_t req,
      input logic [3:0] reg_addr
   );
      wr_targets = req.wr && addr_is(req.addr, reg_addr);
   endfunction

   // True when the address names one of the two trim registers
   function automatic logic is_hit(
      input logic [3:0] a
   );
      is_hit = addr_is(a, `CMOT_ADDR_CM_TRIM) ||
         addr_is(a, `CMOT_ADDR_OFS_TRIM);
   endfunction

   function automatic logic [2:0] cm_code_of(
      input logic [15:0] word
   );
      cm_code_of = word[`CMOT_CM_CODE_MSB:`CMOT_CM_CODE_LSB];
   endfunction

   function automatic logic ofs_pol_of(
      input logic [15:0] word
   );
      ofs_pol_of = word[`CMOT_OFS_POL_BIT];
   endfunction

   function automatic logic [11:0] ofs_size_of(
      input logic [15:0] word
   );
      ofs_size_of = word[`CMOT_OFS_SIZE_MSB:0];
   endfunction

   // Gathers the analog-facing fields from the two stored words
   function automatic cmot_pkg::cmot_trim_t trim_of(
      input logic [15:0] cm_word,
      input logic [15:0] ofs_word
   );
      cmot_pkg::cmot_trim_t t;
      t = '0;
      t.cm_trim_code = cm_code_of(cm_word);
      t.offset_polarity = ofs_pol_of(ofs_word);
      t.offset_size = ofs_size_of(ofs_word);
      trim_of = t;
   endfunction

   // Field resets derive from the reset words so the two cannot drift
   localparam cmot_pkg::cmot_trim_t trim_reset_val =
      trim_of(cm_reset_word, ofs_reset_word);
   localparam logic [7:0] cm_rsv_hi_reset =
      cm_reset_word[15:`CMOT_CM_RSV_HI_LSB];
   localparam logic [4:0] cm_rsv_lo_reset =
      cm_reset_word[`CMOT_CM_RSV_LO_MSB:0];
   localparam logic [2:0] ofs_rsv_reset =
      ofs_reset_word[15:`CMOT_OFS_RSV_LSB];

   always_comb begin
      cm_wr_sel = wr_targets(req_in, `CMOT_ADDR_CM_TRIM);
      ofs_wr_sel = wr_targets(req_in, `CMOT_ADDR_OFS_TRIM);
   end

   always_comb begin
      cm_rd_sel = addr_is(rd_addr_in, `CMOT_ADDR_CM_TRIM);
      ofs_rd_sel = addr_is(rd_addr_in, `CMOT_ADDR_OFS_TRIM);
      rd_hit_next = is_hit(rd_addr_in);
   end

   always_comb begin
      cm_trim_word = {cm_rsv_hi_reg, cm_code_reg, cm_rsv_lo_reg};
      ofs_trim_word = {ofs_rsv_reg, ofs_pol_reg, ofs_size_reg};
   end

   // Unmapped addresses read as zero so a stray read is harmless
   always_comb begin
      if (cm_rd_sel) begin
         rd_data_next = cm_trim_word;
      end else if (ofs_rd_sel) begin
         rd_data_next = ofs_trim_word;
      end else begin
         rd_data_next = 16'h0000;
      end
   end

   always_comb begin
      trim_next = trim_of(cm_trim_word, ofs_trim_word);
   end

   // Reserved bits are not forced: keeping them is the host's duty
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cm_rsv_hi_reg <= cm_rsv_hi_reset;
      end else if (cm_wr_sel) begin
         cm_rsv_hi_reg <= req_in.data[15:`CMOT_CM_RSV_HI_LSB];
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cm_code_reg <= trim_reset_val.cm_trim_code;
      end else if (cm_wr_sel) begin
         cm_code_reg <= cm_code_of(req_in.data);
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cm_rsv_lo_reg <= cm_rsv_lo_reset;
      end else if (cm_wr_sel) begin
         cm_rsv_lo_reg <= req_in.data[`CMOT_CM_RSV_LO_MSB:0];
      end
   end

   // Bits 15:13 stored too, so a faulty write reads back as written
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ofs_rsv_reg <= ofs_rsv_reset;
      end else if (ofs_wr_sel) begin
         ofs_rsv_reg <= req_in.data[15:`CMOT_OFS_RSV_LSB];
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ofs_pol_reg <= trim_reset_val.offset_polarity;
      end else if (ofs_wr_sel) begin
         ofs_pol_reg <= ofs_pol_of(req_in.data);
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ofs_size_reg <= trim_reset_val.offset_size;
      end else if (ofs_wr_sel) begin
         ofs_size_reg <= ofs_size_of(req_in.data);
      end
   end

   // Registered read port: data one cycle after the address
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rd_hit_out <= 1'b0;
      end else begin
         rd_hit_out <= rd_hit_next;
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rd_data_out <= 16'h0000;
      end else begin
         rd_data_out <= rd_data_next;
      end
   end

   // Registered so the analog side sees glitch-free levels
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         trim_out <= trim_reset_val;
      end else begin
         trim_out <= trim_next;
      end
   end

endmodule // cmot_regs
`default_nettype wire

// ### src/cmot_cfg.svh
// Purpose: Offsets, field positions and reset values of the trim registers
// Assumes: 4-bit register address, 16-bit register word
// Notes:   Definitions only
`ifndef CMOT_CFG_SVH
`define CMOT_CFG_SVH

`define CMOT_ADDR_CM_TRIM 4'h1
`define CMOT_ADDR_OFS_TRIM 4'h2
`define CMOT_CM_TRIM_RESET 16'h2A00
`define CMOT_OFS_TRIM_RESET 16'h0000
`define CMOT_CM_CODE_LSB 5
`define CMOT_CM_CODE_MSB 7
`define CMOT_OFS_POL_BIT 12
`define CMOT_OFS_SIZE_MSB 11
`define CMOT_CM_RSV_HI_LSB 8
`define CMOT_CM_RSV_LO_MSB 4
`define CMOT_OFS_RSV_LSB 13
// Nominal common-mode trim step and offset full scale, for reference by the analog side
`define CMOT_CM_STEP_UV 28600
`define CMOT_OFS_FULL_UV 45000

`endif

// ### src/cmot_pkg.sv
// Purpose: Types shared by the trim register bank
// Assumes: Nothing beyond the config header
// Notes:   Write request and trim outputs travel as packed structs
package cmot_pkg;

   typedef struct packed {
      logic wr;
      logic [3:0] addr;
      logic [15:0] data;
   } cmot_req_t;

   typedef struct packed {
      logic [2:0] cm_trim_code;
      logic offset_polarity;
      logic [11:0] offset_size;
   } cmot_trim_t;

endpackage

// ### sim/cmot_regs_props.sv
// Purpose: trim bank checks. Assumes: one clock. Notes: port view only
`timescale 1ns/1ps
`default_nettype none
module cmot_regs_props (
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   input wire cmot_pkg::cmot_req_t req_in,
   input wire logic [3:0] rd_addr_in,
   input wire logic [15:0] rd_data_out,
   input wire logic rd_hit_out,
   input wire cmot_pkg::cmot_trim_t trim_out
);
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!rst_n_in);
   a_cm_code_path: assert property (
      req_in.wr && req_in.addr == 4'h1 |=> ##1
      trim_out.cm_trim_code == $past(req_in.data[7:5], 2)
   ) else $error("cm code path");
   a_ofs_field_path: assert property (
      req_in.wr && req_in.addr == 4'h2 |=> ##1
      trim_out[12:0] == $past(req_in.data[12:0], 2)
   ) else $error("offset field path");
   a_unmapped_zero: assert property (
      !(rd_addr_in inside {4'h1, 4'h2}) |=>
      !rd_hit_out && rd_data_out == 16'h0000
   ) else $error("unmapped read");
   a_read_equals_trim: assert property (
      rd_addr_in == 4'h2 |=>
      rd_hit_out && rd_data_out[12:0] == trim_out[12:0]
   ) else $error("offset readback");
   a_cm_write_readback: assert property (
      req_in.wr && req_in.addr == 4'h1 ##1 rd_addr_in == 4'h1 |=>
      rd_hit_out && rd_data_out == $past(req_in.data, 2)
   ) else $error("cm write readback");
   a_ofs_write_readback: assert property (
      req_in.wr && req_in.addr == 4'h2 ##1 rd_addr_in == 4'h2 |=>
      rd_hit_out && rd_data_out == $past(req_in.data, 2)
   ) else $error("offset write readback");
endmodule // cmot_regs_props
bind cmot_regs cmot_regs_props cmot_regs_props_inst (.ref_clk_in, .rst_n_in,
   .req_in, .rd_addr_in, .rd_data_out, .rd_hit_out, .trim_out);
`default_nettype wire

// ### sim/cmot_host.sv
// Purpose: serial host model. Assumes: caller at rising edge. Notes: writes
`timescale 1ns/1ps
`default_nettype none
module cmot_host (
   input wire logic ref_clk_in,
   output var cmot_pkg::cmot_req_t req_out
);
   initial req_out = '0;
   // Reserved bits forced to their defaults, as the host owes the device
   task automatic wr(input logic [3:0] a, input logic [15:0] v);
      req_out <= {1'b1, a, a == 4'h1 ? {8'h2a, v[7:5], 5'h00} :
         {3'h0, v[12:0]}};
      @(posedge ref_clk_in) req_out.wr <= 1'b0;
   endtask
endmodule // cmot_host
`default_nettype wire

// ### sim/tb_cmot_regs.sv
// Purpose: trim bank bench. Assumes: 125 MHz. Notes: random writes
`timescale 1ns/1ps
`default_nettype none
module tb_cmot_regs;
   logic ref_clk_in, rst_n_in, rd_hit_out;
   logic [3:0] rd_addr_in, wa;
   logic [15:0] rd_data_out, v, exp_cm, exp_ofs;
   logic [32:0] note, exp_q[$];
   cmot_pkg::cmot_req_t req;
   cmot_pkg::cmot_trim_t trim_out;
   int num_errors = 0, comparisons = 0, cyc = 0;
   cmot_host cmot_host_inst (.ref_clk_in(ref_clk_in), .req_out(req));
   cmot_regs cmot_regs_inst (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
      .req_in(req), .rd_addr_in(rd_addr_in), .rd_data_out(rd_data_out),
      .rd_hit_out(rd_hit_out), .trim_out(trim_out));
   task automatic give_verdict;
      if (num_errors == 0 && comparisons > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // Note goes in once the address has been sampled
   task automatic rd(input logic [3:0] a);
      logic [15:0] w;
      w = a == 4'h1 ? exp_cm : (a == 4'h2 ? exp_ofs : 16'h0000);
      rd_addr_in <= a;
      @(posedge ref_clk_in);
      exp_q.push_back({(a == 4'h1 || a == 4'h2), w, exp_cm[7:5],
         exp_ofs[12:0]});
      @(posedge ref_clk_in);
   endtask
   initial begin
      ref_clk_in = 0;
      forever #4 ref_clk_in = ~ref_clk_in;
   end
   always @(negedge ref_clk_in) if (exp_q.size() > 0) begin
      note = exp_q.pop_front();
      comparisons++;
      if ({rd_hit_out, rd_data_out, trim_out} !== note) begin
         num_errors++;
         $display("unexpected hit/read/trim exp %h got %h", note,
            {rd_hit_out, rd_data_out, trim_out});
      end
   end
   always @(posedge ref_clk_in) if (++cyc == 500) begin
      num_errors++;
      give_verdict();
   end
   initial begin
      rst_n_in = 0;
      rd_addr_in = 0;
      exp_cm = 16'h2a00;
      exp_ofs = 16'h0000;
      void'($urandom(32'hf445_5327));
      repeat (8) @(posedge ref_clk_in);
      rst_n_in <= 1;
      rd(4'h1);
      rd(4'h2);
      for (int i = 0; i < 24; i++) begin
         v = 16'($urandom);
         wa = 4'(i) & 4'h3;
         cmot_host_inst.wr(wa, v);
         if (wa == 4'h1) exp_cm = {8'h2a, v[7:5], 5'h00};
         if (wa == 4'h2) exp_ofs = {3'h0, v[12:0]};
         rd(wa);
      end
      // Second reset mid-run must bring both words back to defaults
      rst_n_in <= 0;
      @(posedge ref_clk_in);
      rst_n_in <= 1;
      exp_cm = 16'h2a00;
      exp_ofs = 16'h0000;
      rd(4'h1);
      rd(4'h2);
      give_verdict();
   end
endmodule // tb_cmot_regs
`default_nettype wire
